//--- src/ecs_regs.vh
// register map, field positions, reset values and timing counts for the control signal block
`ifndef ECS_REGS_VH
`define ECS_REGS_VH

// ==========================================================
// register offsets (byte addresses, one aligned word each)
`define ECS_OFS_CTRL        8'h00
`define ECS_OFS_CMD         8'h04
`define ECS_OFS_STATUS      8'h08

// ==========================================================
// control register fields
`define ECS_CTRL_MODE_LO    0
`define ECS_CTRL_MODE_HI    1
`define ECS_CTRL_COMP_LO    2
`define ECS_CTRL_COMP_HI    4
`define ECS_CTRL_WIDE       5
`define ECS_CTRL_GROUP      6
`define ECS_CTRL_HIZ        7
`define ECS_CTRL_RESET      8'h00

// command register bits (write one to request)
`define ECS_CMD_OPERATE     0
`define ECS_CMD_STANDBY     1
`define ECS_CMD_SUSPEND     2

// ==========================================================
// source modes
`define ECS_MODE_DC         2'h0
`define ECS_MODE_PULSE      2'h1
`define ECS_MODE_SWEEP      2'h2

// completion pulse selections
`define ECS_COMP_FRONT      3'h0
`define ECS_COMP_END        3'h1
`define ECS_COMP_HI         3'h2
`define ECS_COMP_GO         3'h3
`define ECS_COMP_LO         3'h4

// limit verdict encodings
`define ECS_VERDICT_HI      2'h1
`define ECS_VERDICT_GO      2'h2
`define ECS_VERDICT_LO      2'h3

// output states
`define ECS_ST_STANDBY      2'h0
`define ECS_ST_OPERATE      2'h1
`define ECS_ST_SUSPEND      2'h2

// ==========================================================
// timing: times in microseconds, counts derived from the clock rate
`define ECS_CLK_MHZ         100
`define ECS_MIN_PULSE_US    10
`define ECS_WIDE_PULSE_US   100
`define ECS_MIN_PULSE_CYC   (`ECS_MIN_PULSE_US * `ECS_CLK_MHZ)
`define ECS_WIDE_PULSE_CYC  (`ECS_WIDE_PULSE_US * `ECS_CLK_MHZ)

`endif

//--- src/ecs_sync.v
// three-stage pin synchroniser with level and edge pulses
`timescale 1ns/1ps

module ecs_sync #(
  parameter INIT = 1'b0
) (
  input  wire aclk,
  input  wire aresetn,
  input  wire pin,
  output reg  level,
  output reg  rise,
  output reg  fall
);

  reg s1;
  reg s2;
  reg s3;

  // ==========================================================
  // s1 feeds s2 only; a change counts once s2 and s3 agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1    <= INIT;
      s2    <= INIT;
      s3    <= INIT;
      level <= INIT;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      s1    <= pin;
      s2    <= s1;
      s3    <= s2;
      rise  <= (s2 == s3) && s3 && !level;
      fall  <= (s2 == s3) && !s3 && level;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end

endmodule

//--- src/ecs_ctrl.v
// external control signal logic: trigger input, completion/sync pulses, output state machine
//
// Summary of operation
// RULE1: active-low start pulse of 10 us or more triggers per source mode or steps sweep.
// RULE2: completion pulse, low for 10 us minimum, selectable start/end/verdict source.
// RULE3: sync pulse for every pulse output and every sweep step advance.
// RULE4: sync pulse never produced in DC source mode.
// RULE5: interlock rising forces Standby; interlock high refuses every Operate request. Code does both only while the state group is selected.
// RULE6: idle input or run/idle input rising moves output into Standby.
// RULE7: run/pause input rising moves output into Suspend.
// RULE8: run/idle or run/pause input falling moves output into Operate.
// RULE9: operate status pin low in Operate, high in Standby or Suspend.
// RULE10: shared terminals carry either the pulse group or the state group.
// RULE11: output pulse width can be switched to 100 us.
// RULE12: far side sends no start pulse in Standby or during state changes.
// RULE13: far side never overlaps start pulse with panel or bus triggers.
// RULE14: burst, no measurement: period 1 ms up to trigger period less margin.
// RULE15: normal or no memory: period at least 10 ms, trigger period 15 ms.
// RULE16: burst with measurement: period at least 2.2 ms, trigger period 2.5 ms.
// RULE17: hold setting bounds against external hold time, 4 ms otherwise.
// RULE18: sweep start to next step equals hold time plus trigger period.
// RULE19: period margin depends on memory mode and period setting.
// RULE20: first trigger after Operate waits 120, 60 or 10 ms by prior state.
// RULE21: next sweep start waits 10 ms after previous sweep completes.
// RULE22: inputs synchronised, edges detected, short start pulses rejected.
// RULE23: interlock Standby beats Suspend, Suspend beats Operate.
`timescale 1ns/1ps
`include "ecs_regs.vh"

module ecs_ctrl #(
  parameter WIDE_PULSE_CYC = `ECS_WIDE_PULSE_CYC
) (
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite register port
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // rear-panel pins
  input  wire        trig_in_n,
  input  wire [4:0]  term_in,
  output wire [4:0]  term_out,
  output reg  [4:0]  term_oe,
  // events from the source and measure engine
  input  wire        meas_start,
  input  wire        meas_done,
  input  wire        period_done,
  input  wire [1:0]  limit_verdict,
  input  wire        pulse_emit,
  input  wire        step_advance,
  input  wire        sweep_done,
  // trigger requests to the engine
  output reg         dc_meas_start,
  output reg         pulse_fire,
  output reg         sweep_start,
  output reg         step_fire,
  output reg  [1:0]  out_state
);

  localparam [9:0]  MIN_CYC  = `ECS_MIN_PULSE_CYC;
  localparam [13:0] NARROW   = `ECS_MIN_PULSE_CYC;
  localparam [13:0] WIDE     = WIDE_PULSE_CYC;
  localparam [1:0]  RESP_OK  = 2'h0;
  localparam [1:0]  RESP_ERR = 2'h2;

  // ==========================================================
  // width of an output pulse for the selected setting
  function [13:0] pulse_len;
    input wide;
    begin
      pulse_len = wide ? WIDE : NARROW; // RULE11
    end
  endfunction

  // true when the byte address names a mapped register
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `ECS_OFS_CTRL) || (a == `ECS_OFS_CMD) || (a == `ECS_OFS_STATUS);
    end
  endfunction

  reg  [7:0]  ctrl;
  reg  [2:0]  cmd_req;
  reg  [7:0]  aw_addr;
  reg         aw_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         w_held;
  reg         sweep_active;
  reg  [9:0]  trig_cnt;
  reg  [13:0] comp_cnt;
  reg  [13:0] sync_cnt;
  reg  [15:0] trig_total;
  reg  [1:0]  next_state;
  reg  [31:0] next_rdata;

  wire [1:0]  src_mode = ctrl[`ECS_CTRL_MODE_HI:`ECS_CTRL_MODE_LO];
  wire [2:0]  comp_sel = ctrl[`ECS_CTRL_COMP_HI:`ECS_CTRL_COMP_LO];
  wire        wide     = ctrl[`ECS_CTRL_WIDE];
  wire        grp      = ctrl[`ECS_CTRL_GROUP];
  wire        wr_go    = aw_held && w_held && !s_axi_bvalid;

  // ==========================================================
  // pin synchronisers; interlock rests high so an open pin refuses Operate while the state group owns the terminals
  wire trig_lvl;
  wire ilk_lvl;
  wire ilk_rise;
  wire idle_rise;
  wire ri_rise;
  wire ri_fall;
  wire rp_rise;
  wire rp_fall;

  ecs_sync #(.INIT(1'b1)) u_trig (
    .aclk(aclk), .aresetn(aresetn), .pin(trig_in_n),
    .level(trig_lvl), .rise(), .fall()
  ); // RULE22
  ecs_sync #(.INIT(1'b1)) u_ilk (
    .aclk(aclk), .aresetn(aresetn), .pin(term_in[0]),
    .level(ilk_lvl), .rise(ilk_rise), .fall()
  ); // RULE22
  ecs_sync #(.INIT(1'b0)) u_idle (
    .aclk(aclk), .aresetn(aresetn), .pin(term_in[1]),
    .level(), .rise(idle_rise), .fall()
  );
  ecs_sync #(.INIT(1'b0)) u_runidle (
    .aclk(aclk), .aresetn(aresetn), .pin(term_in[2]),
    .level(), .rise(ri_rise), .fall(ri_fall)
  );
  ecs_sync #(.INIT(1'b0)) u_runpause (
    .aclk(aclk), .aresetn(aresetn), .pin(term_in[3]),
    .level(), .rise(rp_rise), .fall(rp_fall)
  );

  // ==========================================================
  // state requests; pins only count while the state group owns the terminals
  wire ilk_block = grp && ilk_lvl;                                        // RULE5 RULE10
  wire want_ilk  = grp && ilk_rise;                                       // RULE5
  wire want_stby = cmd_req[`ECS_CMD_STANDBY] || (grp && (idle_rise || ri_rise)); // RULE6
  wire want_sus  = cmd_req[`ECS_CMD_SUSPEND] || (grp && rp_rise);          // RULE7
  wire want_opr  = cmd_req[`ECS_CMD_OPERATE] || (grp && (ri_fall || rp_fall)); // RULE8

  // standby first, then suspend, then operate; operate blocked by interlock
  always @* begin
    next_state = out_state;
    if (want_ilk || want_stby) begin
      next_state = `ECS_ST_STANDBY;           // RULE23
    end else if (want_sus) begin
      next_state = `ECS_ST_SUSPEND;           // RULE23
    end else if (want_opr && !ilk_block) begin
      next_state = `ECS_ST_OPERATE;           // RULE5
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      out_state <= `ECS_ST_STANDBY;
    end else begin
      case (next_state)
        `ECS_ST_STANDBY: out_state <= `ECS_ST_STANDBY;
        `ECS_ST_OPERATE: out_state <= `ECS_ST_OPERATE;
        `ECS_ST_SUSPEND: out_state <= `ECS_ST_SUSPEND;
        default:         out_state <= `ECS_ST_STANDBY;
      endcase
    end
  end

  // ==========================================================
  // start pulse filter: fires once after the low level has lasted the minimum
  wire trig_hit = !trig_lvl && (trig_cnt == MIN_CYC - 10'h001); // RULE22
  // a start outside Operate is dropped to protect the source
  wire trig_ok  = trig_hit && (out_state == `ECS_ST_OPERATE);

  always @(posedge aclk) begin
    if (!aresetn) begin
      trig_cnt <= 10'h000;
    end else if (trig_lvl) begin
      trig_cnt <= 10'h000;
    end else if (trig_cnt != MIN_CYC) begin
      trig_cnt <= trig_cnt + 10'h001;
    end
  end

  // dispatch by source mode; first sweep trigger starts, later ones step
  always @(posedge aclk) begin
    if (!aresetn) begin
      dc_meas_start <= 1'b0;
      pulse_fire    <= 1'b0;
      sweep_start   <= 1'b0;
      step_fire     <= 1'b0;
      sweep_active  <= 1'b0;
      trig_total    <= 16'h0000;
    end else begin
      dc_meas_start <= trig_ok && (src_mode == `ECS_MODE_DC);                     // RULE1
      pulse_fire    <= trig_ok && (src_mode == `ECS_MODE_PULSE);                  // RULE1
      sweep_start   <= trig_ok && (src_mode == `ECS_MODE_SWEEP) && !sweep_active; // RULE1
      step_fire     <= trig_ok && (src_mode == `ECS_MODE_SWEEP) && sweep_active;  // RULE1
      if (trig_ok) begin
        trig_total <= trig_total + 16'h0001;
      end
      // a start arriving with the done event wins over the clear
      if (trig_ok && (src_mode == `ECS_MODE_SWEEP)) begin
        sweep_active <= 1'b1;
      end else if (sweep_done || (out_state != `ECS_ST_OPERATE)) begin
        sweep_active <= 1'b0;
      end
    end
  end

  // ==========================================================
  // completion and sync pulse stretchers; a new event restarts the width
  reg comp_evt;
  always @* begin
    case (comp_sel)
      `ECS_COMP_FRONT: comp_evt = meas_start;
      `ECS_COMP_END:   comp_evt = meas_done || period_done;
      `ECS_COMP_HI:    comp_evt = meas_done && (limit_verdict == `ECS_VERDICT_HI);
      `ECS_COMP_GO:    comp_evt = meas_done && (limit_verdict == `ECS_VERDICT_GO);
      `ECS_COMP_LO:    comp_evt = meas_done && (limit_verdict == `ECS_VERDICT_LO);
      default:         comp_evt = 1'b0;
    endcase
  end

  // sync only in pulse or sweep mode, never in dc mode
  wire sync_evt = ((src_mode == `ECS_MODE_PULSE) && pulse_emit) ||
                  ((src_mode == `ECS_MODE_SWEEP) && step_advance); // RULE3 RULE4

  always @(posedge aclk) begin
    if (!aresetn) begin
      comp_cnt <= 14'h0000;
      sync_cnt <= 14'h0000;
    end else begin
      if (comp_evt) begin
        comp_cnt <= pulse_len(wide);           // RULE2
      end else if (comp_cnt != 14'h0000) begin
        comp_cnt <= comp_cnt - 14'h0001;
      end
      if (sync_evt) begin
        sync_cnt <= pulse_len(wide);           // RULE3
      end else if (sync_cnt != 14'h0000) begin
        sync_cnt <= sync_cnt - 14'h0001;
      end
    end
  end

  // ==========================================================
  // terminal drive: open drain, enable pulls low; group picks the function
  assign term_out = 5'h00;

  always @(posedge aclk) begin
    if (!aresetn) begin
      term_oe <= 5'h00;
    end else if (grp) begin
      term_oe <= {out_state == `ECS_ST_OPERATE, 4'h0}; // RULE9 RULE10
    end else begin
      term_oe <= {3'h0, sync_cnt != 14'h0000, comp_cnt != 14'h0000}; // RULE2 RULE10
    end
  end

  // ==========================================================
  // axi4-lite write channel: address and data accepted in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OK;
      ctrl         <= `ECS_CTRL_RESET;
      cmd_req      <= 3'h0;
    end else begin
      cmd_req <= 3'h0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr) ? RESP_OK : RESP_ERR;
        if (w_strb[0] && (aw_addr == `ECS_OFS_CTRL)) begin
          ctrl <= w_data[7:0];
        end
        if (w_strb[0] && (aw_addr == `ECS_OFS_CMD)) begin
          cmd_req <= w_data[2:0];
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // axi4-lite read channel: one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    case (s_axi_araddr)
      `ECS_OFS_CTRL:   next_rdata = {24'h000000, ctrl};
      `ECS_OFS_STATUS: next_rdata = {trig_total, 11'h000, ilk_block,
                                     sweep_active, ctrl[`ECS_CTRL_HIZ], out_state};
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- sim/ecs_ctrl_chk.sv
// port checker for the external control signal block
`timescale 1ns/1ps
`include "ecs_regs.vh"

// ==========================================
// checker
module ecs_ctrl_chk #(
  parameter WIDE_PULSE_CYC = 10000
) (
  input wire       aclk,
  input wire       aresetn,
  input wire       trig_in_n,
  input wire [4:0] term_in,
  input wire [4:0] term_oe,
  input wire       meas_start,
  input wire       meas_done,
  input wire       period_done,
  input wire       pulse_emit,
  input wire       step_advance,
  input wire       dc_meas_start,
  input wire       pulse_fire,
  input wire       sweep_start,
  input wire       step_fire,
  input wire [1:0] out_state
);
  reg  [11:0] low_cnt;
  reg  [15:0] comp_cnt;
  wire        fire = dc_meas_start | pulse_fire | sweep_start | step_fire;

  // unbroken low time on the start pin; a refused short low must not count towards the next
  always @(posedge aclk)
    if (!aresetn || fire || trig_in_n) low_cnt <= 12'h000;
    else if (!trig_in_n && low_cnt != 12'hfff) low_cnt <= low_cnt + 12'h001;

  // run length of the completion pulse, read when it ends
  always @(posedge aclk)
    if (!aresetn || !term_oe[0]) comp_cnt <= 16'h0000;
    else comp_cnt <= comp_cnt + 16'h0001;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_fire_operate: assert property (fire |-> $past(out_state) == `ECS_ST_OPERATE)
    else $error("start taken outside operate");
  a_start_width: assert property (fire |-> low_cnt >= 12'h3e8)
    else $error("start taken on a short low");
  a_oper_pin: assert property (term_oe[4] |-> $past(out_state) == `ECS_ST_OPERATE)
    else $error("status pin low outside operate");
  // event loads the stretcher, the pin follows one edge later: cause lies two samples back
  a_sync_cause: assert property ($rose(term_oe[1]) |->
    $past(pulse_emit || step_advance, 2))
    else $error("sync pulse without cause");
  a_comp_cause: assert property ($rose(term_oe[0]) |->
    $past(meas_start || meas_done || period_done, 2))
    else $error("completion pulse without cause");
  a_comp_width: assert property ($fell(term_oe[0]) |->
    comp_cnt >= 16'h03e8 || comp_cnt == WIDE_PULSE_CYC)
    else $error("completion pulse too short");
  a_intlk_drop: assert property ($rose(term_in[0]) && term_oe[4] |->
    ##[2:8] out_state == `ECS_ST_STANDBY)
    else $error("interlock did not force standby");
  a_intlk_hold: assert property (term_in[0] [*8] ##1 term_in[0] |-> !term_oe[4])
    else $error("operate while interlock high");
  a_idle_rise: assert property (($rose(term_in[1]) || $rose(term_in[2])) && term_oe[4] |->
    ##[2:8] out_state == `ECS_ST_STANDBY)
    else $error("idle rise did not give standby");
  a_pause_rise: assert property ($rose(term_in[3]) && term_oe[4] && term_in[2:0] == 3'h0 |->
    ##[2:8] out_state == `ECS_ST_SUSPEND)
    else $error("pause rise did not give suspend");
endmodule

bind ecs_ctrl ecs_ctrl_chk #(.WIDE_PULSE_CYC(WIDE_PULSE_CYC)) u_chk (
  .aclk, .aresetn, .trig_in_n, .term_in, .term_oe, .meas_start, .meas_done,
  .period_done, .pulse_emit, .step_advance, .dc_meas_start, .pulse_fire,
  .sweep_start, .step_fire, .out_state
);

//--- sim/ecs_far_end.sv
// far-side equipment model: start pin source and control pin levels
`timescale 1ns/1ps

// ==========================================
// partner
module ecs_far_end #(
  parameter GAP = 200
) (
  input  wire       aclk,
  input  wire [4:0] term_oe,
  output reg        trig_in_n,
  output wire [4:0] term_in
);
  reg [4:0] drv;

  // open-drain terminals: a pulled-low pin reads low whatever we drive
  assign term_in = drv & ~term_oe;

  // rest levels before the first command
  initial begin
    trig_in_n = 1'b1;
    drv = 5'h00;
  end

  // one start pulse, used only in operate and never beside another trigger source
  task automatic start(input integer len);
    @(posedge aclk);
    trig_in_n <= 1'b0;
    repeat (len) @(posedge aclk);
    trig_in_n <= 1'b1;
    // spacing scaled down from the documented milliseconds to keep runs short
    repeat (GAP) @(posedge aclk);
  endtask

  // change the masked control pins just after an edge
  task automatic pins(input [4:0] mask, input [4:0] val);
    @(posedge aclk);
    drv <= (drv & ~mask) | (val & mask);
  endtask
endmodule

//--- sim/test_external_control_signal_logic.sv
// self-checking bench for the external control signal block
`timescale 1ns/1ps
`include "ecs_regs.vh"

// ==========================================
// bench top
module test_external_control_signal_logic;
  localparam WIDE = 200;
  reg         aclk;
  reg         aresetn;
  reg  [7:0]  awaddr;
  reg         awvalid;
  reg  [31:0] wdata;
  reg         wvalid;
  reg         bready;
  reg  [7:0]  araddr;
  reg         arvalid;
  reg         rready;
  reg  [4:0]  evb;
  reg  [1:0]  verdict;
  reg  [31:0] rd_v;
  wire        awready, wready, bvalid, arready, rvalid, trig_n;
  wire [1:0]  bresp, rresp, out_state;
  wire [31:0] rdata;
  wire [4:0]  term_in, term_out, term_oe;
  wire [3:0]  fires;
  integer     mismatches, samples_checked;
  integer     cnt [0:3];

  ecs_ctrl #(.WIDE_PULSE_CYC(WIDE)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .trig_in_n(trig_n), .term_in(term_in), .term_out(term_out), .term_oe(term_oe),
    .meas_start(evb[0]), .meas_done(evb[1]), .period_done(evb[2]), .limit_verdict(verdict),
    .pulse_emit(evb[3]), .step_advance(evb[4]), .sweep_done(1'b0),
    .dc_meas_start(fires[0]), .pulse_fire(fires[1]), .sweep_start(fires[2]),
    .step_fire(fires[3]), .out_state(out_state));

  ecs_far_end u_far (.aclk(aclk), .term_oe(term_oe), .trig_in_n(trig_n), .term_in(term_in));

  // free-running 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // count engine requests of each kind
  always @(posedge aclk) begin
    cnt[0] <= cnt[0] + fires[0];
    cnt[1] <= cnt[1] + fires[1];
    cnt[2] <= cnt[2] + fires[2];
    cnt[3] <= cnt[3] + fires[3];
  end

  task automatic chk(input string nm, input [31:0] seen, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("wrong value %0s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wt(input integer n);
    repeat (n) @(posedge aclk);
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && dd)) begin
      @(negedge aclk);
      ad = ad | awready;
      dd = dd | wready;
      @(posedge aclk);
      if (ad) awvalid <= 1'b0;
      if (dd) wvalid <= 1'b0;
    end
    bready <= 1'b1;
    do @(negedge aclk); while (!bvalid);
    chk("bresp", bresp, er);
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input [7:0] a, input [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    rd_v = rdata;
    chk("rresp", rresp, er);
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // one-cycle engine event, then look after it has landed
  task automatic ev(input integer k, input [1:0] v);
    @(posedge aclk);
    evb <= 5'h01 << k;
    verdict <= v;
    @(posedge aclk);
    evb <= 5'h00;
    // stretcher loads on this edge, the pin follows on the next
    @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic width(input [31:0] exp);
    reg [31:0] n;
    n = 0;
    while (term_oe[0] === 1'b1) begin
      n = n + 1;
      @(negedge aclk);
    end
    chk("comp width", n, exp);
  endtask

  task automatic st(input [4:0] m, input [4:0] v, input [1:0] es);
    u_far.pins(m, v);
    wt(12);
    chk("state", out_state, es);
    chk("status pin", term_oe[4], es == `ECS_ST_OPERATE);
  endtask

  task automatic t_regs;
    chk("state", out_state, `ECS_ST_STANDBY);
    chk("term_oe", term_oe, 5'h00);
    chk("term_out", term_out, 5'h00);
    rd(`ECS_OFS_CTRL, 2'h0);
    chk("ctrl", rd_v, `ECS_CTRL_RESET);
    wr(`ECS_OFS_CTRL, 32'h000000a6, 2'h0);
    rd(`ECS_OFS_CTRL, 2'h0);
    chk("ctrl", rd_v, 32'h000000a6);
    rd(`ECS_OFS_STATUS, 2'h0);
    chk("status", rd_v[2:0], 3'h4);
    rd(`ECS_OFS_CMD, 2'h0);
    chk("cmd", rd_v, 32'h0);
    wr(8'h40, 32'h1, 2'h2);
    rd(8'h40, 2'h2);
    chk("unmapped", rd_v, 32'h0);
  endtask

  // each mode: short start refused, full start taken once (sweep takes a second one as a step), then sync
  task automatic t_modes;
    integer m;
    for (m = 0; m < 3; m = m + 1) begin
      wr(`ECS_OFS_CTRL, m, 2'h0);
      wr(`ECS_OFS_CMD, 32'h1, 2'h0);
      wt(20);
      // clear away from the edge so the counting process cannot race the clear
      @(negedge aclk);
      for (int k = 0; k < 4; k++) cnt[k] = 0;
      u_far.start(990);
      u_far.start(1100);
      if (m == 2) u_far.start(1100);
      chk("dc starts", cnt[0], m == 0);
      chk("pulses", cnt[1], m == 1);
      chk("sweeps", cnt[2], m == 2);
      chk("steps", cnt[3], m == 2);
      ev(m == 2 ? 4 : 3, 2'h0);
      chk("sync pin", term_oe[1], m != 0);
      wt(1100);
      wr(`ECS_OFS_CMD, 32'h2, 2'h0);
    end
  endtask

  // every completion selection against every event kind
  task automatic t_comp;
    integer s, v;
    for (s = 0; s < 5; s = s + 1) begin
      wr(`ECS_OFS_CTRL, s << 2, 2'h0);
      ev(0, 2'h0);
      chk("comp pin", term_oe[0], s == 0);
      wt(1100);
      ev(2, 2'h0);
      chk("comp pin", term_oe[0], s == 1);
      wt(1100);
      for (v = 1; v < 4; v = v + 1) begin
        ev(1, v);
        chk("comp pin", term_oe[0], s == 1 || s == v + 1);
        width(s == 1 || s == v + 1 ? 1000 : 0);
        wt(100);
      end
    end
    wr(`ECS_OFS_CTRL, 32'h24, 2'h0);
    ev(1, 2'h2);
    width(WIDE);
  endtask

  task automatic t_states;
    wr(`ECS_OFS_CTRL, 32'h40, 2'h0);
    ev(0, 2'h0);
    chk("pulse pins", term_oe[1:0], 2'h0);
    wr(`ECS_OFS_CMD, 32'h1, 2'h0);
    st(5'h00, 5'h00, `ECS_ST_OPERATE);
    wr(`ECS_OFS_CMD, 32'h4, 2'h0);
    st(5'h00, 5'h00, `ECS_ST_SUSPEND);
    st(5'h08, 5'h08, `ECS_ST_SUSPEND);
    st(5'h08, 5'h00, `ECS_ST_OPERATE);
    st(5'h02, 5'h02, `ECS_ST_STANDBY);
    st(5'h06, 5'h04, `ECS_ST_STANDBY);
    st(5'h04, 5'h00, `ECS_ST_OPERATE);
    st(5'h04, 5'h04, `ECS_ST_STANDBY);
    st(5'h04, 5'h00, `ECS_ST_OPERATE);
    st(5'h0a, 5'h0a, `ECS_ST_STANDBY);
    st(5'h0a, 5'h00, `ECS_ST_OPERATE);
    st(5'h01, 5'h01, `ECS_ST_STANDBY);
    wr(`ECS_OFS_CMD, 32'h1, 2'h0);
    st(5'h04, 5'h04, `ECS_ST_STANDBY);
    st(5'h04, 5'h00, `ECS_ST_STANDBY);
    st(5'h01, 5'h00, `ECS_ST_STANDBY);
  endtask

  task automatic stop_test;
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // main sequence: reset for ten cycles, then the scenarios
  initial begin
    mismatches = 0;
    samples_checked = 0;
    aresetn = 1'b0;
    {awaddr, awvalid, wdata, wvalid, bready} = 0;
    {araddr, arvalid, rready, evb, verdict} = 0;
    wt(10);
    aresetn <= 1'b1;
    t_regs;
    t_modes;
    t_comp;
    t_states;
    stop_test;
  end

  // a hang past the expected run length is a failure
  initial begin
    #1000000;
    mismatches = mismatches + 1;
    stop_test;
  end
endmodule
